// [bench/ipl4_mac_model.sv]
`timescale 1ns/10ps
module ipl4_mac_model #(
	parameter int OFF_W = 14
) (
	input wire logic clk_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_sop_o,
	output logic rx_eop_o,
	output logic [15:0] etype_o,
	output logic [OFF_W-1:0] l2_end_o
);
	logic [7:0] frm [0:127];
	// Quiet line, untagged frames
	initial begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		rx_sop_o = 1'b0;
		rx_eop_o = 1'b0;
		etype_o = 16'h0000;
		l2_end_o = OFF_W'(14);
	end
	// No valid byte; data flips so a stale byte never matches
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_i);
			rx_valid_o <= 1'b0;
			rx_data_o <= ~rx_data_o;
		end
	endtask : idle
	// One frame, optional stall after byte 20
	task automatic send(input int len, input int gap, input logic [15:0] et);
		for (int i = 0; i < len; i++) begin
			@(posedge clk_i);
			etype_o <= et;
			rx_data_o <= frm[i];
			rx_valid_o <= 1'b1;
			rx_sop_o <= (i == 0);
			rx_eop_o <= (i == len - 1);
			if (i == 20) idle(gap);
		end
		idle(1);
	endtask : send
endmodule : ipl4_mac_model

// [bench/ipl4_parser_monitor.sv]
`timescale 1ns/10ps
module ipl4_parser_monitor #(
	parameter int OFF_W = 14
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic RX_VALID_I,
	input wire logic RX_SOP_I,
	input wire logic [15:0] ETYPE_I,
	input wire logic [OFF_W-1:0] L2_END_I,
	input wire logic PARSE_DONE_O,
	input wire logic IPV6_O,
	input wire logic [OFF_W-1:0] L3_HEADER_END_OFFSET_O,
	input wire logic [7:0] L4_PROTO_O,
	input wire logic [2:0] L4_CLASS_O,
	input wire logic CHAIN_ERR_O,
	input wire logic TRUNC_O,
	input wire logic [3:0] TCP_HLEN_O,
	input wire logic TCP_HLEN_ERR_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	logic [OFF_W-1:0] l3_span;
	// Bytes walked from L3 start
	assign l3_span = L3_HEADER_END_OFFSET_O - L2_END_I;
	property p_done_pulse;
		PARSE_DONE_O |-> $past(RX_VALID_I) ##1 !PARSE_DONE_O;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a lone pulse");
	property p_tcp;
		PARSE_DONE_O && L4_CLASS_O == 3'h1 |-> L4_PROTO_O == 8'h06 && !CHAIN_ERR_O;
	endproperty
	a_tcp: assert property (p_tcp) else $error("tcp class with wrong code");
	property p_udp;
		PARSE_DONE_O && L4_CLASS_O inside {3'h2, 3'h3} |-> L4_PROTO_O == (L4_CLASS_O == 3'h2 ? 8'h11 : 8'h88);
	endproperty
	a_udp: assert property (p_udp) else $error("udp class with wrong code");
	property p_icmp;
		PARSE_DONE_O && L4_CLASS_O inside {3'h4, 3'h5, 3'h6}
			|-> L4_PROTO_O == (L4_CLASS_O == 3'h4 ? 8'h01 : (L4_CLASS_O == 3'h5 ? 8'h02 : 8'h3A));
	endproperty
	a_icmp: assert property (p_icmp) else $error("icmp class with wrong code");
	property p_esp;
		PARSE_DONE_O && L4_CLASS_O == 3'h7 |-> L4_PROTO_O == 8'h32;
	endproperty
	a_esp: assert property (p_esp) else $error("esp class with wrong code");
	property p_chain;
		PARSE_DONE_O && CHAIN_ERR_O |-> L4_CLASS_O == 3'h0;
	endproperty
	a_chain: assert property (p_chain) else $error("class kept on chain error");
	property p_hlen;
		PARSE_DONE_O && L4_CLASS_O == 3'h1 && !TRUNC_O |-> TCP_HLEN_ERR_O == (TCP_HLEN_O < 4'h5);
	endproperty
	a_hlen: assert property (p_hlen) else $error("tcp length flag wrong");
	property p_etype;
		PARSE_DONE_O && ETYPE_I != 16'h86DD |-> !IPV6_O;
	endproperty
	a_etype: assert property (p_etype) else $error("ipv6 flag on other ethertype");
	property p_l3;
		PARSE_DONE_O && IPV6_O && !TRUNC_O |-> l3_span >= OFF_W'(40) && l3_span[1:0] == 2'h0;
	endproperty
	a_l3: assert property (p_l3) else $error("l3 end before base end");
	property p_hold;
		PARSE_DONE_O && !(RX_VALID_I && RX_SOP_I) |=> $stable(L4_CLASS_O) && $stable(L3_HEADER_END_OFFSET_O);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved before next frame");
endmodule : ipl4_parser_monitor

bind ipl4_parser ipl4_parser_monitor #(.OFF_W(OFF_W)) u_mon (.CLK_I(CLK_I), .RST_I(RST_I),
	.RX_VALID_I(RX_VALID_I), .RX_SOP_I(RX_SOP_I), .ETYPE_I(ETYPE_I), .L2_END_I(L2_END_I),
	.PARSE_DONE_O(PARSE_DONE_O), .IPV6_O(IPV6_O), .L3_HEADER_END_OFFSET_O(L3_HEADER_END_OFFSET_O),
	.L4_PROTO_O(L4_PROTO_O), .L4_CLASS_O(L4_CLASS_O), .CHAIN_ERR_O(CHAIN_ERR_O), .TRUNC_O(TRUNC_O),
	.TCP_HLEN_O(TCP_HLEN_O), .TCP_HLEN_ERR_O(TCP_HLEN_ERR_O));

// [bench/ipv6_l4_header_parser_tb_top.sv]
`timescale 1ns/10ps
module ipv6_l4_header_parser_tb_top;
	typedef struct {
		logic [31:0] c;
		int n;
		logic [7:0] len;
		logic [7:0] b12;
		logic [2:0] cls;
		int l3;
		logic err;
	} ipl4_row_t;
	localparam int NR = 16;
	logic CLK_I, RST_I, rxv, sop, eop, done, ipv6, cerr, trunc, auth, frag, herr;
	logic [7:0] rxd, tos, ttl, proto, ityp, icod;
	logic [15:0] et, sp, dp, w2;
	logic [13:0] l2e, l3e;
	logic [2:0] cls, ecn;
	logic [3:0] hlen;
	logic [5:0] flags;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	ipl4_row_t rows [NR] = '{
		'{32'h06000000, 1, 8'h00, 8'h51, 3'h1, 54, 1'b0},
		'{32'h11000000, 1, 8'h00, 8'h51, 3'h2, 54, 1'b0},
		'{32'h88000000, 1, 8'h00, 8'h51, 3'h3, 54, 1'b0},
		'{32'h01000000, 1, 8'h00, 8'h51, 3'h4, 54, 1'b0},
		'{32'h02000000, 1, 8'h00, 8'h51, 3'h5, 54, 1'b0},
		'{32'h3A000000, 1, 8'h00, 8'h51, 3'h6, 54, 1'b0},
		'{32'h00110000, 2, 8'h01, 8'h51, 3'h2, 70, 1'b0},
		'{32'h3C060000, 2, 8'h00, 8'h41, 3'h1, 62, 1'b0},
		'{32'h2B3A0000, 2, 8'h02, 8'h51, 3'h6, 78, 1'b0},
		'{32'h2C060000, 2, 8'h05, 8'hF1, 3'h1, 62, 1'b0},
		'{32'h33060000, 2, 8'h01, 8'h51, 3'h1, 66, 1'b0},
		'{32'h32000000, 1, 8'h00, 8'h51, 3'h7, 54, 1'b0},
		'{32'hFD000000, 1, 8'h00, 8'h51, 3'h0, 54, 1'b0},
		'{32'h3C2B3C06, 4, 8'h00, 8'h51, 3'h1, 78, 1'b0},
		'{32'h00000600, 3, 8'h00, 8'h51, 3'h0, 62, 1'b1},
		'{32'h3C3C0600, 3, 8'h00, 8'h51, 3'h0, 62, 1'b1}};
	ipl4_mac_model mac (.clk_i(CLK_I), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_sop_o(sop),
		.rx_eop_o(eop), .etype_o(et), .l2_end_o(l2e));
	ipl4_parser dut (.CLK_I(CLK_I), .RST_I(RST_I), .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_SOP_I(sop),
		.RX_EOP_I(eop), .ETYPE_I(et), .L2_END_I(l2e), .PARSE_DONE_O(done), .IPV6_O(ipv6), .TOS_O(tos),
		.TTL_O(ttl), .L3_HEADER_END_OFFSET_O(l3e), .L4_PROTO_O(proto), .L4_CLASS_O(cls),
		.CHAIN_ERR_O(cerr), .TRUNC_O(trunc), .AUTH_O(auth), .FRAG_O(frag), .SRC_PORT_O(sp),
		.DST_PORT_O(dp), .UDP_WORD2_O(w2), .TCP_HLEN_O(hlen), .TCP_HLEN_ERR_O(herr),
		.TCP_FLAGS_O(flags), .TCP_ECN_O(ecn), .ICMP_TYPE_O(ityp), .ICMP_CODE_O(icod));
	// Clock, 50 ns period
	initial begin
		CLK_I = 1'b0;
		forever #25 CLK_I = ~CLK_I;
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	// Frame image: base header, extension chain, L4 bytes
	task automatic build(input ipl4_row_t r, output int pos, output logic ea, output logic ef);
		logic [7:0] k;
		pos = 54;
		ea = 1'b0;
		ef = 1'b0;
		for (int i = 0; i < 128; i++) mac.frm[i] = 8'h00;
		mac.frm[14] = 8'h6A;
		mac.frm[15] = 8'h50;
		mac.frm[20] = r.c[31:24];
		mac.frm[21] = 8'h40;
		for (int i = 0; i < r.n - 1; i++) begin
			k = r.c[31-8*i -: 8];
			ea |= (k == 8'h33);
			ef |= (k == 8'h2C);
			mac.frm[pos] = r.c[23-8*i -: 8];
			mac.frm[pos+1] = r.len;
			pos += (k == 8'h33) ? (r.len + 2) * 4 : (k == 8'h2C) ? 8 : (r.len + 1) * 8;
		end
		{mac.frm[pos], mac.frm[pos+1], mac.frm[pos+2], mac.frm[pos+3]} = 32'h1234ABCD;
		mac.frm[pos+5] = 8'h10;
		mac.frm[pos+12] = r.b12;
		mac.frm[pos+13] = 8'hD5;
	endtask : build
	// Send a frame and wait for the done pulse
	task automatic run(input int len, input int gap, input logic [15:0] e);
		fork
			mac.send(len, gap, e);
			begin
				int w;
				w = 0;
				do begin
					@(posedge CLK_I);
					#1;
					w++;
				end while (done !== 1'b1 && w < 300);
				chk("done", done, 1'b1);
			end
		join
		#1;
	endtask : run
	// Cycle ceiling
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		ipl4_row_t r;
		int p;
		logic ea, ef;
		RST_I = 1'b1;
		repeat (8) @(posedge CLK_I);
		RST_I <= 1'b0;
		#1;
		chk("rst_done", done, 1'b0);
		chk("rst_class", cls, 3'h0);
		$display("reset done");
		for (int i = 0; i < NR; i++) begin
			r = rows[i];
			build(r, p, ea, ef);
			run(p + 24, (i % 3) * 2, 16'h86DD);
			chk("class", cls, r.cls);
			chk("l3_end", l3e, r.l3);
			chk("chain_err", cerr, r.err);
			chk("ipv6", ipv6, 1'b1);
			chk("trunc_row", trunc, 1'b0);
			chk("tos", tos, 8'hA5);
			chk("ttl", ttl, 8'h40);
			chk("auth", auth, ea);
			chk("frag", frag, ef);
			if (!r.err) chk("proto", proto, r.c[31-8*(r.n-1) -: 8]);
			if (r.cls inside {3'h1, 3'h2, 3'h3}) begin
				chk("sport", sp, 16'h1234);
				chk("dport", dp, 16'hABCD);
			end
			if (r.cls inside {3'h2, 3'h3}) chk("word2", w2, 16'h0010);
			if (r.cls == 3'h1) begin
				chk("hlen", hlen, r.b12[7:4]);
				chk("hlen_err", herr, r.b12[7:4] < 4'h5);
				chk("flags", flags, 6'h15);
				chk("ecn", ecn, {r.b12[0], 2'h3});
			end
			if (r.cls inside {3'h4, 3'h5, 3'h6}) begin
				chk("icmp_type", ityp, 8'h12);
				chk("icmp_code", icod, 8'h34);
			end
			$display("row %0d done", i);
		end
		build(rows[0], p, ea, ef);
		run(60, 0, 16'h0800);
		chk("ipv6_other", ipv6, 1'b0);
		chk("class_other", cls, 3'h0);
		$display("other ethertype done");
		run(30, 0, 16'h86DD);
		chk("trunc", trunc, 1'b1);
		chk("ipv6_trunc", ipv6, 1'b1);
		$display("truncation done");
		fork
			mac.send(p + 24, 0, 16'h86DD);
			begin
				repeat (30) @(posedge CLK_I);
				RST_I <= 1'b1;
				@(posedge CLK_I);
				#1;
				chk("ipv6_rst", ipv6, 1'b0);
				@(posedge CLK_I);
				RST_I <= 1'b0;
			end
		join
		run(p + 24, 0, 16'h86DD);
		chk("class_after_rst", cls, 3'h1);
		$display("mid reset done");
		complete_run();
	end
endmodule : ipv6_l4_header_parser_tb_top

// [pkg/ipl4_pkg.sv]
package ipl4_pkg;
	localparam int HPOS_W = 12;
	typedef logic [HPOS_W-1:0] ipl4_pos_t;

	localparam logic [15:0] ETYPE_IPV6 = 16'h86DD;

	// Base header layout
	localparam ipl4_pos_t BASE_LEN = 12'h028;
	localparam ipl4_pos_t BASE_TC_HI_POS = 12'h000;
	localparam ipl4_pos_t BASE_TC_LO_POS = 12'h001;
	localparam ipl4_pos_t BASE_NH_POS = 12'h006;
	localparam ipl4_pos_t BASE_HL_POS = 12'h007;

	// Extension header layout
	localparam ipl4_pos_t EXT_NH_POS = 12'h000;
	localparam ipl4_pos_t EXT_LEN_POS = 12'h001;
	localparam ipl4_pos_t EXT_GEN_BIAS = 12'h001;
	localparam ipl4_pos_t EXT_AH_BIAS = 12'h002;
	localparam int EXT_GEN_SHIFT = 3;
	localparam int EXT_AH_SHIFT = 2;
	localparam ipl4_pos_t FRAG_LEN = 12'h008;

	// Upper-layer layout
	localparam ipl4_pos_t L4_SPORT_HI = 12'h000;
	localparam ipl4_pos_t L4_SPORT_LO = 12'h001;
	localparam ipl4_pos_t L4_DPORT_HI = 12'h002;
	localparam ipl4_pos_t L4_DPORT_LO = 12'h003;
	localparam ipl4_pos_t TCP_DOFF_POS = 12'h00C;
	localparam ipl4_pos_t TCP_FLAG_POS = 12'h00D;
	localparam logic [3:0] TCP_DOFF_MIN = 4'h5;
	localparam ipl4_pos_t UDP_W2_HI = 12'h004;
	localparam ipl4_pos_t UDP_W2_LO = 12'h005;
	localparam ipl4_pos_t UDP_LAST = 12'h007;
	localparam ipl4_pos_t ICMP_TYPE_POS = 12'h000;
	localparam ipl4_pos_t ICMP_CODE_POS = 12'h001;
	localparam ipl4_pos_t ICMP_LAST = 12'h003;

	// Next-header codes
	localparam logic [7:0] NH_HBH = 8'h00;
	localparam logic [7:0] NH_DST = 8'h3C;
	localparam logic [7:0] NH_RT = 8'h2B;
	localparam logic [7:0] NH_FRAG = 8'h2C;
	localparam logic [7:0] NH_AH = 8'h33;
	localparam logic [7:0] NH_ESP = 8'h32;
	localparam logic [7:0] NH_TCP = 8'h06;
	localparam logic [7:0] NH_UDP = 8'h11;
	localparam logic [7:0] NH_UDPL = 8'h88;
	localparam logic [7:0] NH_ICMP4 = 8'h01;
	localparam logic [7:0] NH_IGMP = 8'h02;
	localparam logic [7:0] NH_ICMP6 = 8'h3A;

	// Seen-mask bit positions
	localparam int SEEN_HBH = 0;
	localparam int SEEN_DST_PRE = 1;
	localparam int SEEN_RT = 2;
	localparam int SEEN_FRAG = 3;
	localparam int SEEN_AH = 4;
	localparam int SEEN_DST_POST = 5;
	localparam int SEEN_W = 6;

	typedef enum logic [2:0] {
		CLS_NONE = 3'b000,
		CLS_TCP = 3'b001,
		CLS_UDP = 3'b010,
		CLS_UDPL = 3'b011,
		CLS_ICMP4 = 3'b100,
		CLS_IGMP = 3'b101,
		CLS_ICMP6 = 3'b110,
		CLS_ESP = 3'b111
	} ipl4_cls_t;

	typedef enum logic [2:0] {
		ACT_EXT = 3'b000,
		ACT_AH = 3'b001,
		ACT_FRAG = 3'b010,
		ACT_L4 = 3'b011,
		ACT_STOP = 3'b100,
		ACT_ERR = 3'b101
	} ipl4_act_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'b000,
		ST_BASE = 3'b001,
		ST_EXT = 3'b010,
		ST_L4 = 3'b011,
		ST_DONE = 3'b100
	} ipl4_state_t;
endpackage : ipl4_pkg

// [rtl/ipl4_nh_dec.sv]
`timescale 1ns/10ps
module ipl4_nh_dec (
	input wire logic [7:0] code_i,
	input wire logic first_i,
	input wire logic [ipl4_pkg::SEEN_W-1:0] seen_i,
	output ipl4_pkg::ipl4_act_t act_o,
	output logic [ipl4_pkg::SEEN_W-1:0] set_o,
	output ipl4_pkg::ipl4_cls_t cls_o
);
	// Classify a next-header code against the chain seen so far
	always_comb begin
		act_o = ipl4_pkg::ACT_L4;
		set_o = '0;
		cls_o = ipl4_pkg::CLS_NONE;
		case (code_i)
			ipl4_pkg::NH_HBH: begin
				if (first_i && !seen_i[ipl4_pkg::SEEN_HBH]) begin
					act_o = ipl4_pkg::ACT_EXT;
					set_o[ipl4_pkg::SEEN_HBH] = 1'b1;
				end else begin
					act_o = ipl4_pkg::ACT_ERR;
				end
			end
			ipl4_pkg::NH_DST: begin
				if (seen_i[ipl4_pkg::SEEN_RT]) begin
					act_o = seen_i[ipl4_pkg::SEEN_DST_POST] ? ipl4_pkg::ACT_ERR : ipl4_pkg::ACT_EXT;
					set_o[ipl4_pkg::SEEN_DST_POST] = 1'b1;
				end else begin
					act_o = seen_i[ipl4_pkg::SEEN_DST_PRE] ? ipl4_pkg::ACT_ERR : ipl4_pkg::ACT_EXT;
					set_o[ipl4_pkg::SEEN_DST_PRE] = 1'b1;
				end
			end
			ipl4_pkg::NH_RT: begin
				act_o = seen_i[ipl4_pkg::SEEN_RT] ? ipl4_pkg::ACT_ERR : ipl4_pkg::ACT_EXT;
				set_o[ipl4_pkg::SEEN_RT] = 1'b1;
			end
			ipl4_pkg::NH_FRAG: begin
				act_o = seen_i[ipl4_pkg::SEEN_FRAG] ? ipl4_pkg::ACT_ERR : ipl4_pkg::ACT_FRAG;
				set_o[ipl4_pkg::SEEN_FRAG] = 1'b1;
			end
			ipl4_pkg::NH_AH: begin
				act_o = seen_i[ipl4_pkg::SEEN_AH] ? ipl4_pkg::ACT_ERR : ipl4_pkg::ACT_AH;
				set_o[ipl4_pkg::SEEN_AH] = 1'b1;
			end
			ipl4_pkg::NH_ESP: begin
				act_o = ipl4_pkg::ACT_STOP;
				cls_o = ipl4_pkg::CLS_ESP;
			end
			ipl4_pkg::NH_TCP: cls_o = ipl4_pkg::CLS_TCP;
			ipl4_pkg::NH_UDP: cls_o = ipl4_pkg::CLS_UDP;
			ipl4_pkg::NH_UDPL: cls_o = ipl4_pkg::CLS_UDPL;
			ipl4_pkg::NH_ICMP4: cls_o = ipl4_pkg::CLS_ICMP4;
			ipl4_pkg::NH_IGMP: cls_o = ipl4_pkg::CLS_IGMP;
			ipl4_pkg::NH_ICMP6: cls_o = ipl4_pkg::CLS_ICMP6;
			default: act_o = ipl4_pkg::ACT_STOP;
		endcase
	end
endmodule : ipl4_nh_dec

// [rtl/ipl4_parser.sv]
`timescale 1ns/10ps
module ipl4_parser #(
	parameter int OFF_W = 14
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	input wire logic RX_SOP_I,
	input wire logic RX_EOP_I,
	input wire logic [15:0] ETYPE_I,
	input wire logic [OFF_W-1:0] L2_END_I,
	output logic PARSE_DONE_O,
	output logic IPV6_O,
	output logic [7:0] TOS_O,
	output logic [7:0] TTL_O,
	output logic [OFF_W-1:0] L3_HEADER_END_OFFSET_O,
	output logic [7:0] L4_PROTO_O,
	output logic [2:0] L4_CLASS_O,
	output logic CHAIN_ERR_O,
	output logic TRUNC_O,
	output logic AUTH_O,
	output logic FRAG_O,
	output logic [15:0] SRC_PORT_O,
	output logic [15:0] DST_PORT_O,
	output logic [15:0] UDP_WORD2_O,
	output logic [3:0] TCP_HLEN_O,
	output logic TCP_HLEN_ERR_O,
	output logic [5:0] TCP_FLAGS_O,
	output logic [2:0] TCP_ECN_O,
	output logic [7:0] ICMP_TYPE_O,
	output logic [7:0] ICMP_CODE_O
);
	typedef struct packed {
		// Walk control
		ipl4_pkg::ipl4_state_t st;
		ipl4_pkg::ipl4_act_t kind;
		ipl4_pkg::ipl4_pos_t pos;
		ipl4_pkg::ipl4_pos_t hlen;

		// Chain bookkeeping
		logic first;
		logic [ipl4_pkg::SEEN_W-1:0] seen;
		logic [7:0] nh;
		logic [OFF_W-1:0] cnt;

		// Base header results
		logic done;
		logic ipv6;
		logic [7:0] tos;
		logic [7:0] ttl;
		logic [OFF_W-1:0] l3end;

		// Chain outcome
		logic [7:0] proto;
		ipl4_pkg::ipl4_cls_t cls;
		logic chain_err;
		logic trunc;
		logic auth;
		logic frag;

		// Upper-layer fields
		logic [15:0] sport;
		logic [15:0] dport;
		logic [15:0] w2;
		logic [3:0] doff;
		logic doff_err;
		logic [5:0] flags;
		logic [2:0] ecn;
		logic [7:0] itype;
		logic [7:0] icode;
	} ipl4_st_t;

	localparam ipl4_st_t ST_RST = '0;

	// Walk state and its next value
	ipl4_st_t state_ff;
	ipl4_st_t nxt_state;

	// Decoder outputs
	ipl4_pkg::ipl4_act_t dec_act;
	logic [ipl4_pkg::SEEN_W-1:0] dec_set;
	ipl4_pkg::ipl4_cls_t dec_cls;

	// Extension header size from its kind and length byte
	function automatic ipl4_pkg::ipl4_pos_t ext_len(input ipl4_pkg::ipl4_act_t kind, input logic [7:0] len);
		ipl4_pkg::ipl4_pos_t wide;
		wide = {4'h0, len};
		case (kind)
			ipl4_pkg::ACT_AH: ext_len = (wide + ipl4_pkg::EXT_AH_BIAS) << ipl4_pkg::EXT_AH_SHIFT;
			ipl4_pkg::ACT_FRAG: ext_len = ipl4_pkg::FRAG_LEN;
			default: ext_len = (wide + ipl4_pkg::EXT_GEN_BIAS) << ipl4_pkg::EXT_GEN_SHIFT;
		endcase
	endfunction : ext_len

	// Last fixed byte of each upper-layer header that is read
	function automatic ipl4_pkg::ipl4_pos_t l4_last(input ipl4_pkg::ipl4_cls_t cls);
		case (cls)
			ipl4_pkg::CLS_TCP: l4_last = ipl4_pkg::TCP_FLAG_POS;
			ipl4_pkg::CLS_UDP: l4_last = ipl4_pkg::UDP_LAST;
			ipl4_pkg::CLS_UDPL: l4_last = ipl4_pkg::UDP_LAST;
			default: l4_last = ipl4_pkg::ICMP_LAST;
		endcase
	endfunction : l4_last

	// Next-header decode of the header just walked
	ipl4_nh_dec u_dec (
		.code_i(state_ff.nh),
		.first_i(state_ff.first),
		.seen_i(state_ff.seen),
		.act_o(dec_act),
		.set_o(dec_set),
		.cls_o(dec_cls)
	);

	// Byte-wise walk of base, extension chain and upper-layer header
	always_comb begin
		logic [OFF_W-1:0] cur_off;
		ipl4_pkg::ipl4_pos_t pos;
		logic hdr_end;
		logic is_port;
		cur_off = '0;
		pos = '0;
		hdr_end = 1'b0;
		is_port = 1'b0;
		nxt_state = state_ff;
		nxt_state.done = 1'b0;
		// Only qualified bytes move the walk
		if (RX_VALID_I) begin
			// Frame offset of this byte, zero at start of frame
			cur_off = RX_SOP_I ? '0 : state_ff.cnt;
			if (RX_SOP_I) begin
				nxt_state = ST_RST;
			end
			nxt_state.cnt = cur_off + OFF_W'(1);
			// Layer 3 start point reached
			if (nxt_state.st == ipl4_pkg::ST_WAIT && cur_off == L2_END_I) begin
				if (ETYPE_I == ipl4_pkg::ETYPE_IPV6) begin
					nxt_state.st = ipl4_pkg::ST_BASE;
					nxt_state.pos = '0;
					nxt_state.hlen = ipl4_pkg::BASE_LEN;
					nxt_state.first = 1'b1;
					nxt_state.ipv6 = 1'b1;
				end else begin
					nxt_state.st = ipl4_pkg::ST_DONE;
					nxt_state.done = 1'b1;
				end
			end

			// Byte position inside the current header
			pos = nxt_state.pos;
			nxt_state.pos = pos + ipl4_pkg::ipl4_pos_t'(1);
			// Upper-layer kinds that carry port numbers
			is_port = nxt_state.cls == ipl4_pkg::CLS_TCP || nxt_state.cls == ipl4_pkg::CLS_UDP ||
				nxt_state.cls == ipl4_pkg::CLS_UDPL;
			// Field capture per walk state
			case (nxt_state.st)
				ipl4_pkg::ST_BASE: begin
					if (pos == ipl4_pkg::BASE_TC_HI_POS) begin
						nxt_state.tos[7:4] = RX_DATA_I[3:0];
					end
					if (pos == ipl4_pkg::BASE_TC_LO_POS) begin
						nxt_state.tos[3:0] = RX_DATA_I[7:4];
					end
					if (pos == ipl4_pkg::BASE_NH_POS) begin
						nxt_state.nh = RX_DATA_I;
					end
					if (pos == ipl4_pkg::BASE_HL_POS) begin
						nxt_state.ttl = RX_DATA_I;
					end
					// Base header is a fixed forty octets
					hdr_end = pos == nxt_state.hlen - ipl4_pkg::ipl4_pos_t'(1);
				end
				ipl4_pkg::ST_EXT: begin
					if (pos == ipl4_pkg::EXT_NH_POS) begin
						nxt_state.nh = RX_DATA_I;
					end
					if (pos == ipl4_pkg::EXT_LEN_POS) begin
						nxt_state.hlen = ext_len(nxt_state.kind, RX_DATA_I);
					end
					// Size known once the length byte is in
					hdr_end = pos == nxt_state.hlen - ipl4_pkg::ipl4_pos_t'(1);
				end
				ipl4_pkg::ST_L4: begin
					// Field location only, checksums pass untouched
					if (is_port && pos == ipl4_pkg::L4_SPORT_HI) begin
						nxt_state.sport[15:8] = RX_DATA_I;
					end
					if (is_port && pos == ipl4_pkg::L4_SPORT_LO) begin
						nxt_state.sport[7:0] = RX_DATA_I;
					end
					if (is_port && pos == ipl4_pkg::L4_DPORT_HI) begin
						nxt_state.dport[15:8] = RX_DATA_I;
					end
					if (is_port && pos == ipl4_pkg::L4_DPORT_LO) begin
						nxt_state.dport[7:0] = RX_DATA_I;
					end
					// TCP length and control bits
					if (nxt_state.cls == ipl4_pkg::CLS_TCP && pos == ipl4_pkg::TCP_DOFF_POS) begin
						nxt_state.doff = RX_DATA_I[7:4];
						nxt_state.doff_err = RX_DATA_I[7:4] < ipl4_pkg::TCP_DOFF_MIN;
						nxt_state.ecn[2] = RX_DATA_I[0];
					end
					if (nxt_state.cls == ipl4_pkg::CLS_TCP && pos == ipl4_pkg::TCP_FLAG_POS) begin
						nxt_state.ecn[1:0] = RX_DATA_I[7:6];
						nxt_state.flags = RX_DATA_I[5:0];
					end
					// Second word of UDP and UDPLite
					if (is_port && nxt_state.cls != ipl4_pkg::CLS_TCP && pos == ipl4_pkg::UDP_W2_HI) begin
						nxt_state.w2[15:8] = RX_DATA_I;
					end
					if (is_port && nxt_state.cls != ipl4_pkg::CLS_TCP && pos == ipl4_pkg::UDP_W2_LO) begin
						nxt_state.w2[7:0] = RX_DATA_I;
					end
					// Message type and code
					if (!is_port && pos == ipl4_pkg::ICMP_TYPE_POS) begin
						nxt_state.itype = RX_DATA_I;
					end
					if (!is_port && pos == ipl4_pkg::ICMP_CODE_POS) begin
						nxt_state.icode = RX_DATA_I;
					end
					// Header read to its last fixed byte
					if (pos == l4_last(nxt_state.cls)) begin
						nxt_state.st = ipl4_pkg::ST_DONE;
						nxt_state.done = 1'b1;
					end
				end
				default: begin
					nxt_state.pos = pos;
				end
			endcase
			// Step to the following header
			if (hdr_end) begin
				nxt_state.l3end = cur_off + OFF_W'(1);
				nxt_state.first = 1'b0;
				nxt_state.pos = '0;
				// Code that ended this header decides the next
				nxt_state.proto = state_ff.nh;
				nxt_state.cls = dec_cls;
				case (dec_act)
					ipl4_pkg::ACT_EXT, ipl4_pkg::ACT_AH, ipl4_pkg::ACT_FRAG: begin
						nxt_state.st = ipl4_pkg::ST_EXT;
						nxt_state.kind = dec_act;
						nxt_state.hlen = ipl4_pkg::FRAG_LEN;
						nxt_state.seen = state_ff.seen | dec_set;
						nxt_state.auth = state_ff.auth | (dec_act == ipl4_pkg::ACT_AH);
						nxt_state.frag = state_ff.frag | (dec_act == ipl4_pkg::ACT_FRAG);
					end
					ipl4_pkg::ACT_L4: begin
						nxt_state.st = ipl4_pkg::ST_L4;
					end
					default: begin
						nxt_state.st = ipl4_pkg::ST_DONE;
						nxt_state.done = 1'b1;
						nxt_state.chain_err = dec_act == ipl4_pkg::ACT_ERR;
					end
				endcase
			end
			// Frame ended before the parse finished
			if (RX_EOP_I && nxt_state.st != ipl4_pkg::ST_DONE) begin
				nxt_state.trunc = nxt_state.st != ipl4_pkg::ST_WAIT;
				nxt_state.st = ipl4_pkg::ST_DONE;
				nxt_state.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_ff <= ST_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Results straight from the state register
	assign PARSE_DONE_O = state_ff.done;
	assign IPV6_O = state_ff.ipv6;
	assign TOS_O = state_ff.tos;
	assign TTL_O = state_ff.ttl;
	assign L3_HEADER_END_OFFSET_O = state_ff.l3end;

	// Chain outcome flags
	assign L4_PROTO_O = state_ff.proto;
	assign L4_CLASS_O = state_ff.cls;
	assign CHAIN_ERR_O = state_ff.chain_err;
	assign TRUNC_O = state_ff.trunc;
	assign AUTH_O = state_ff.auth;
	assign FRAG_O = state_ff.frag;

	// Port numbers and second word
	assign SRC_PORT_O = state_ff.sport;
	assign DST_PORT_O = state_ff.dport;
	assign UDP_WORD2_O = state_ff.w2;

	// TCP length, flags and congestion bits
	assign TCP_HLEN_O = state_ff.doff;
	assign TCP_HLEN_ERR_O = state_ff.doff_err;
	assign TCP_FLAGS_O = state_ff.flags;
	assign TCP_ECN_O = state_ff.ecn;

	// Message type and code
	assign ICMP_TYPE_O = state_ff.itype;
	assign ICMP_CODE_O = state_ff.icode;
endmodule : ipl4_parser
